// ### design/scoc_pkg.sv
// Constants and types for the secondary clock output control block
// What this block does
// - The primary clock times the primary side and the secondary clock feedback times the secondary side.
// - In synchronous mode ten secondary clock outputs follow the primary clock in phase.
// - In synchronous mode software can switch off single secondary clock outputs through per-output disable bits.
// - In synchronous mode a serial mask is captured once primary reset is released while secondary reset is held.
// - Captured mask bits are shifted into the mask register, read back in the status register, and switch off matching outputs.
// - A mask input held low leaves all outputs running; held high drives all outputs high.
// - One shared input is the serial mask in synchronous mode and the clock source in asynchronous mode.
// - In asynchronous mode the outputs are derived from the asynchronous clock input.
// - In asynchronous mode with divider strap 0 the outputs run at half the asynchronous clock rate.
// - With the power clock strap high, entering D3hot puts the bus in B2 and drives all outputs to 0.
// - With the power clock strap low, entering D3hot leaves the secondary clocks alone.
// - In synchronous normal operation the speed strap high selects 66 MHz and low selects 33 MHz.
// - In synchronous test mode the speed strap is scan enable: low means shift, high means parallel.
// - Two mode-select inputs pick synchronous or asynchronous clocking; the other two codes are reserved.
// - Secondary reset is asserted while primary reset is asserted or the secondary reset control bit is set.
package scoc_pkg;
    localparam int SCOC_NUM_CLKS = 10;
    localparam int SCOC_ADDR_W = 4;
    localparam int SCOC_CNT_W = 4;

    // Register byte offsets
    localparam logic [SCOC_ADDR_W-1:0] SCOC_REG_CTRL = 4'h0;
    localparam logic [SCOC_ADDR_W-1:0] SCOC_REG_DISABLE = 4'h4;
    localparam logic [SCOC_ADDR_W-1:0] SCOC_REG_STATUS = 4'h8;

    // Control register fields
    localparam int SCOC_CTRL_SEC_RST = 0;
    localparam int SCOC_CTRL_PWR_LO = 1;
    localparam int SCOC_CTRL_PWR_HI = 2;

    // Status register fields
    localparam int SCOC_ST_MASK_LO = 0;
    localparam int SCOC_ST_MODE_LO = 16;
    localparam int SCOC_ST_RESERVED = 18;
    localparam int SCOC_ST_SPEED66 = 19;
    localparam int SCOC_ST_SCAN_PAR = 20;
    localparam int SCOC_ST_B2 = 21;
    localparam int SCOC_ST_SEC_RST = 22;

    localparam logic [1:0] SCOC_PWR_D0 = 2'h0;
    localparam logic [1:0] SCOC_PWR_D3HOT = 2'h3;
    localparam logic [1:0] SCOC_MODE_SYNC = 2'h2;
    localparam logic [1:0] SCOC_MODE_ASYNC = 2'h3;
    localparam logic [SCOC_NUM_CLKS-1:0] SCOC_DIS_RESET = 10'h000;
    localparam logic [31:0] SCOC_DATA_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        SCOC_HOLD = 3'b001,
        SCOC_SHIFT = 3'b010,
        SCOC_RUN = 3'b100
    } scoc_phase_type;

    typedef struct packed {
        logic primary_reset_n;
        logic [1:0] mode_select;
        logic speed_config_strap;
        logic pm_clock_control_strap;
        logic test_mode;
    } scoc_straps_type;

    typedef struct packed {
        logic [SCOC_ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } scoc_bus_req_type;

    typedef struct packed {
        scoc_phase_type phase;
        logic [SCOC_CNT_W-1:0] shift_cnt;
        logic [SCOC_NUM_CLKS-1:0] mask;
        logic [SCOC_NUM_CLKS-1:0] sw_disable;
        logic sec_rst_bit;
        logic [1:0] pwr_state;
        logic pclk_q;
        logic fb_q;
        logic aclk_q;
        logic div_tog;
        logic [SCOC_NUM_CLKS-1:0] clk_out;
        logic sec_reset_n;
        logic b2;
        logic speed66;
        logic scan_parallel;
        logic pri_tick;
        logic sec_tick;
        logic waitreq;
        logic [31:0] readdata;
    } scoc_state_type;
endpackage

// ### design/scoc_top.sv
// Secondary clock output control: clock gating, mask capture, reset and register slave
`timescale 1ns/1ps
module scoc_top
    import scoc_pkg::*;
#(
    parameter int NUM_CLKS = SCOC_NUM_CLKS
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_primary_clock,
    input wire logic i_secondary_clock_feedback_in,
    input wire logic i_serial_clock_mask_in,
    input wire scoc_straps_type i_straps,
    input wire scoc_bus_req_type i_bus,
    output logic o_waitrequest,
    output logic [31:0] o_readdata,
    output logic [NUM_CLKS-1:0] o_secondary_clock_outputs,
    output logic o_secondary_reset_n,
    output logic o_secondary_bus_b2,
    output logic o_speed_66mhz,
    output logic o_scan_parallel,
    output logic o_primary_tick,
    output logic o_secondary_tick
);

    scoc_state_type s;
    scoc_state_type next_s;

    function automatic logic is_mode(input logic [1:0] sel, input logic [1:0] code);
        is_mode = (sel == code);
    endfunction

    logic sync_mode;
    logic async_mode;
    logic pclk_rise;
    logic aclk_rise;
    logic d3_gate;
    logic bus_go;
    logic [31:0] status_word;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode of straps and edges
    always_comb begin
        sync_mode = is_mode(i_straps.mode_select, SCOC_MODE_SYNC);
        async_mode = is_mode(i_straps.mode_select, SCOC_MODE_ASYNC);
        pclk_rise = i_primary_clock && !s.pclk_q;
        // Shared pin read as clock source only in asynchronous mode
        aclk_rise = async_mode && i_serial_clock_mask_in && !s.aclk_q;
        d3_gate = i_straps.pm_clock_control_strap && (s.pwr_state == SCOC_PWR_D3HOT);
        bus_go = (i_bus.read || i_bus.write) && !s.waitreq;
        status_word = SCOC_DATA_ZERO;
        status_word[SCOC_ST_MASK_LO +: NUM_CLKS] = s.mask;
        status_word[SCOC_ST_MODE_LO +: 2] = i_straps.mode_select;
        status_word[SCOC_ST_RESERVED] = !sync_mode && !async_mode;
        status_word[SCOC_ST_SPEED66] = s.speed66;
        status_word[SCOC_ST_SCAN_PAR] = s.scan_parallel;
        status_word[SCOC_ST_B2] = s.b2;
        status_word[SCOC_ST_SEC_RST] = !s.sec_reset_n;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_s = s;
        next_s.pclk_q = i_primary_clock;
        next_s.fb_q = i_secondary_clock_feedback_in;
        next_s.aclk_q = async_mode && i_serial_clock_mask_in;
        next_s.pri_tick = pclk_rise;
        next_s.sec_tick = i_secondary_clock_feedback_in && !s.fb_q;

        // Mask capture sequence
        case (s.phase)
            SCOC_HOLD: begin
                next_s.shift_cnt = '0;
                if (i_straps.primary_reset_n && sync_mode) begin
                    next_s.phase = SCOC_SHIFT;
                end else if (i_straps.primary_reset_n) begin
                    next_s.phase = SCOC_RUN;
                end
            end
            SCOC_SHIFT: begin
                if (pclk_rise) begin
                    next_s.mask = {s.mask[NUM_CLKS-2:0], i_serial_clock_mask_in};
                    next_s.shift_cnt = s.shift_cnt + 1'b1;
                    if (s.shift_cnt == SCOC_CNT_W'(NUM_CLKS - 1)) begin
                        next_s.phase = SCOC_RUN;
                    end
                end
            end
            SCOC_RUN: begin
                next_s.shift_cnt = '0;
            end
            default: begin
                next_s.phase = SCOC_HOLD;
            end
        endcase
        if (!i_straps.primary_reset_n) begin
            next_s.phase = SCOC_HOLD;
        end

        // Secondary reset held through the capture window
        next_s.sec_reset_n = i_straps.primary_reset_n && !s.sec_rst_bit
                             && (next_s.phase == SCOC_RUN);

        // Divider toggles on each asynchronous clock rise
        if (aclk_rise) begin
            next_s.div_tog = !s.div_tog;
        end

        // Secondary clock outputs
        for (int i = 0; i < NUM_CLKS; i++) begin
            if (d3_gate) begin
                next_s.clk_out[i] = 1'b0;
            end else if (async_mode && i_straps.speed_config_strap) begin
                next_s.clk_out[i] = i_serial_clock_mask_in;
            end else if (async_mode) begin
                next_s.clk_out[i] = aclk_rise ? !s.div_tog : s.div_tog;
            end else if (sync_mode && (s.mask[i] || s.sw_disable[i])) begin
                next_s.clk_out[i] = 1'b1;
            end else if (sync_mode) begin
                next_s.clk_out[i] = i_primary_clock;
            end else begin
                next_s.clk_out[i] = 1'b0;
            end
        end
        next_s.b2 = d3_gate;

        // Speed and scan straps share one pin
        next_s.speed66 = sync_mode && !i_straps.test_mode && i_straps.speed_config_strap;
        next_s.scan_parallel = sync_mode && i_straps.test_mode && i_straps.speed_config_strap;

        // Avalon-MM slave: one wait cycle, then completion
        next_s.waitreq = !((i_bus.read || i_bus.write) && s.waitreq);
        next_s.readdata = SCOC_DATA_ZERO;
        if ((i_bus.read || i_bus.write) && s.waitreq && i_bus.read) begin
            case (i_bus.address)
                SCOC_REG_CTRL: begin
                    next_s.readdata[SCOC_CTRL_SEC_RST] = s.sec_rst_bit;
                    next_s.readdata[SCOC_CTRL_PWR_HI:SCOC_CTRL_PWR_LO] = s.pwr_state;
                end
                SCOC_REG_DISABLE: begin
                    next_s.readdata[NUM_CLKS-1:0] = s.sw_disable;
                end
                SCOC_REG_STATUS: begin
                    next_s.readdata = status_word;
                end
                default: begin
                    next_s.readdata = SCOC_DATA_ZERO;
                end
            endcase
        end
        if (bus_go && i_bus.write) begin
            case (i_bus.address)
                SCOC_REG_CTRL: begin
                    next_s.sec_rst_bit = i_bus.writedata[SCOC_CTRL_SEC_RST];
                    next_s.pwr_state = i_bus.writedata[SCOC_CTRL_PWR_HI:SCOC_CTRL_PWR_LO];
                end
                SCOC_REG_DISABLE: begin
                    next_s.sw_disable = i_bus.writedata[NUM_CLKS-1:0];
                end
                default: begin
                    next_s.sw_disable = s.sw_disable;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            s.phase <= SCOC_HOLD;
            s.shift_cnt <= '0;
            s.mask <= SCOC_DIS_RESET;
            s.sw_disable <= SCOC_DIS_RESET;
            s.sec_rst_bit <= 1'b0;
            s.pwr_state <= SCOC_PWR_D0;
            s.pclk_q <= 1'b0;
            s.fb_q <= 1'b0;
            s.aclk_q <= 1'b0;
            s.div_tog <= 1'b0;
            s.clk_out <= '0;
            s.sec_reset_n <= 1'b0;
            s.b2 <= 1'b0;
            s.speed66 <= 1'b0;
            s.scan_parallel <= 1'b0;
            s.pri_tick <= 1'b0;
            s.sec_tick <= 1'b0;
            s.waitreq <= 1'b1;
            s.readdata <= SCOC_DATA_ZERO;
        end else begin
            s <= next_s;
        end
    end

    always_comb begin
        o_waitrequest = s.waitreq;
        o_readdata = s.readdata;
        o_secondary_clock_outputs = s.clk_out;
        o_secondary_reset_n = s.sec_reset_n;
        o_secondary_bus_b2 = s.b2;
        o_speed_66mhz = s.speed66;
        o_scan_parallel = s.scan_parallel;
        o_primary_tick = s.pri_tick;
        o_secondary_tick = s.sec_tick;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    sec_reset_primary_a: assert property (!i_straps.primary_reset_n |=> !o_secondary_reset_n)
        else $error("secondary reset not asserted with primary reset");
    sec_reset_bit_a: assert property (s.sec_rst_bit |=> !o_secondary_reset_n)
        else $error("secondary reset control bit ignored");
    d3_outputs_low_a: assert property (d3_gate |=> (o_secondary_clock_outputs == '0) && o_secondary_bus_b2)
        else $error("outputs not low in D3hot with clock control strap");
    d3_no_effect_a: assert property (!i_straps.pm_clock_control_strap |=> !o_secondary_bus_b2)
        else $error("B2 entered with clock control strap low");
    sync_follow_a: assert property (sync_mode && !d3_gate && (s.mask == '0) && (s.sw_disable == '0)
        |=> o_secondary_clock_outputs == {NUM_CLKS{$past(i_primary_clock)}})
        else $error("synchronous outputs do not follow primary clock");
    disabled_high_a: assert property (sync_mode && !d3_gate && s.sw_disable[0] |=> o_secondary_clock_outputs[0])
        else $error("disabled output not held high");
    mask_window_a: assert property (s.phase == SCOC_SHIFT |-> !o_secondary_reset_n)
        else $error("mask captured outside secondary reset");
    mask_shift_a: assert property (s.phase == SCOC_SHIFT && pclk_rise && i_straps.primary_reset_n
        |=> s.mask[0] == $past(i_serial_clock_mask_in))
        else $error("mask bit not shifted in");
    half_rate_a: assert property (async_mode && !d3_gate && !i_straps.speed_config_strap && aclk_rise
        |=> o_secondary_clock_outputs[0] != $past(o_secondary_clock_outputs[0]))
        else $error("divider output did not toggle");
    full_rate_a: assert property (async_mode && !d3_gate && i_straps.speed_config_strap
        |=> o_secondary_clock_outputs[0] == $past(i_serial_clock_mask_in))
        else $error("undivided output does not follow async clock");
    speed_sel_a: assert property (sync_mode && !i_straps.test_mode |=> o_speed_66mhz == $past(i_straps.speed_config_strap))
        else $error("speed selection wrong");
    bus_answer_a: assert property ((i_bus.read || i_bus.write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest)
        else $error("bus answer not one cycle after request");
    scan_sel_a: assert property (sync_mode && i_straps.test_mode
        |=> o_scan_parallel == $past(i_straps.speed_config_strap))
        else $error("scan operation selection wrong");
    reserved_off_a: assert property (!sync_mode && !async_mode |=> o_secondary_clock_outputs == '0)
        else $error("outputs running in a reserved mode");
    pri_tick_a: assert property (pclk_rise |=> o_primary_tick)
        else $error("primary clock rise not flagged");
    sec_tick_a: assert property (!i_secondary_clock_feedback_in |=> !o_secondary_tick)
        else $error("secondary tick without feedback rise");

endmodule

// ### tb/scoc_partner.sv
// Board model: primary clock, clock loop-back and the shared mask or clock pin
`timescale 1ns/1ps
module scoc_partner (
    input wire logic i_clk,
    input wire logic i_async,
    input wire logic i_arun,
    input wire logic i_load,
    input wire logic [9:0] i_word,
    input wire logic i_out0,
    output logic o_pclk,
    output logic o_fb,
    output logic o_pin
);
    logic pc = 1'b0;
    logic ak = 1'b0;
    logic [1:0] ac = 2'h0;
    logic [9:0] sr = 10'h000;
    initial o_pclk = 1'b0;
    initial o_fb = 1'b0;
    assign o_pin = i_async ? ak : sr[9];
    always @(posedge i_clk) begin
        pc <= ~pc;
        if (pc) begin
            o_pclk <= ~o_pclk;
        end
        o_fb <= i_out0;
        // New mask bit after each primary clock fall, first bit first
        if (i_load) begin
            sr <= i_word;
        end else if (pc && o_pclk) begin
            sr <= {sr[8:0], i_word[0]};
        end
        if (i_arun) begin
            ac <= (ac == 2'h2) ? 2'h0 : ac + 2'h1;
            if (ac == 2'h2) begin
                ak <= ~ak;
            end
        end
    end
endmodule

// ### tb/scoc_top_tb.sv
// Self-checking bench for the secondary clock output control block
`timescale 1ns/1ps
module scoc_top_tb;
    import scoc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, ld = 1'b0, asy = 1'b0, ar = 1'b0, mon = 1'b0, ton = 1'b0;
    logic pq = 1'b0, fq = 1'b0, et = 1'b0, es = 1'b0, aq = 1'b0, oq = 1'b0, cen = 1'b0;
    logic [9:0] wd = 10'h000, mm = 10'h000, dm = 10'h000, eo = 10'h000;
    logic [31:0] q, rs = 32'h329CFAC0;
    scoc_straps_type st = '{1'b0, SCOC_MODE_SYNC, 1'b1, 1'b1, 1'b0};
    scoc_bus_req_type bq = '0;
    int error_cnt = 0, checks = 0, md = 0, ir = 0, oc = 0;
    logic pclk, fb, pin, w_wait, w_rn, w_b2, w_66, w_scan, w_pt, w_st;
    logic [31:0] w_rd;
    logic [9:0] w_out;
    always #12.5 clk = ~clk;
    scoc_top uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_primary_clock(pclk), .i_secondary_clock_feedback_in(fb),
        .i_serial_clock_mask_in(pin), .i_straps(st), .i_bus(bq), .o_waitrequest(w_wait), .o_readdata(w_rd),
        .o_secondary_clock_outputs(w_out), .o_secondary_reset_n(w_rn), .o_secondary_bus_b2(w_b2),
        .o_speed_66mhz(w_66), .o_scan_parallel(w_scan), .o_primary_tick(w_pt), .o_secondary_tick(w_st));
    scoc_partner board (.i_clk(clk), .i_async(asy), .i_arun(ar), .i_load(ld), .i_word(wd), .i_out0(w_out[0]),
        .o_pclk(pclk), .o_fb(fb), .o_pin(pin));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        bq <= '{address: a, read: !w, write: w, writedata: d};
        @(posedge clk);
        while (w_wait !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) error_cnt++;
        q = w_rd;
        bq <= '0;
    endtask
    task automatic run(input int n, input string name);
        repeat (2) @(posedge clk);
        mon = 1'b1;
        repeat (n) @(posedge clk);
        mon = 1'b0;
        $display("test %s done", name);
    endtask
    task automatic capture(input logic [9:0] w);
        int n;
        n = 0;
        st.primary_reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk(w_rn, 0);
        @(negedge pclk);
        @(posedge clk);
        wd <= w;
        ld <= 1'b1;
        st.primary_reset_n <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
        while (w_rn !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk(n > 30 && n < 50, 1);
        mm = w;
        bus(0, SCOC_REG_STATUS, 0);
        chk(q[9:0], w);
        run(20, "capture");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Reference model, one cycle behind the sampled inputs
    always @(posedge clk) begin
        pq <= pclk;
        fq <= fb;
        et <= pclk & ~pq;
        es <= fb & ~fq;
        eo <= md == 0 ? {10{pclk}} | mm | dm : md == 1 ? {10{pin}} : 10'h000;
        aq <= pin;
        oq <= w_out[0];
        if (cen && pin && !aq) ir++;
        if (cen && w_out[0] !== oq) oc++;
    end
    always @(negedge clk) begin
        if (ton) begin
            chk(w_pt, et);
            chk(w_st, es);
        end
        if (mon) chk(w_out, eo);
    end
    initial begin
        #(25ns * 6000);
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        ton <= 1'b1;
        capture(10'(rnd()));
        chk(q[19:16], 4'hA);
        dm = 10'(rnd());
        bus(1, SCOC_REG_DISABLE, {22'h0, dm});
        bus(0, SCOC_REG_DISABLE, 0);
        chk(q, {22'h0, dm});
        run(20, "disable");
        bus(0, 4'hC, 0);
        chk(q, 0);
        bus(1, SCOC_REG_CTRL, 1);
        repeat (2) @(posedge clk);
        chk(w_rn, 0);
        bus(1, SCOC_REG_CTRL, 6);
        md = 2;
        run(20, "d3hot");
        chk(w_b2, 1);
        st.pm_clock_control_strap <= 1'b0;
        md = 0;
        run(20, "d3hot strap low");
        chk(w_b2, 0);
        bus(1, SCOC_REG_CTRL, 0);
        dm = 10'h000;
        bus(1, SCOC_REG_DISABLE, 0);
        capture(10'h000);
        capture(10'h3FF);
        st.test_mode <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            st.speed_config_strap <= s[0];
            repeat (3) @(posedge clk);
            chk(w_scan, s);
            chk(w_66, 0);
        end
        st.test_mode <= 1'b0;
        md = 2;
        for (int m = 0; m < 2; m++) begin
            st.mode_select <= m[1:0];
            bus(0, SCOC_REG_STATUS, 0);
            chk(q[18], 1);
            run(10, "reserved");
        end
        st.mode_select <= SCOC_MODE_ASYNC;
        st.speed_config_strap <= 1'b1;
        asy <= 1'b1;
        ar <= 1'b1;
        md = 1;
        run(30, "async undivided");
        ar <= 1'b0;
        st.speed_config_strap <= 1'b0;
        repeat (5) @(posedge clk);
        cen <= 1'b1;
        ar <= 1'b1;
        repeat (48) @(posedge clk);
        ar <= 1'b0;
        repeat (6) @(posedge clk);
        cen <= 1'b0;
        chk(oc, ir);
        chk(ir, 8);
        $display("test async divided done");
        end_of_test();
    end
endmodule
